// [bench/counter_trigger_filter_prescale_tb_top.sv]
// Bench for the counter front end: AHB-Lite register tasks, pin stimulus
// Assumes one bus master and the terminal model driving every pin
`timescale 1ns/1ns
`include "ctr_trig_map.svh"
module counter_trigger_filter_prescale_tb_top;
   logic        clk_sys, resetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, q, base;
   logic [1:0]  htrans, srcPin, gatePin, armPin, ctrOut, tcPulse;
   logic [2:0]  hsize;
   logic [5:0]  syncBusLine;
   int          fail_count = 0, cmp_count = 0, tc0 = 0, tc1 = 0;
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   counter_trigger_filter_prescale #(.LONG_FILT_N(20)) dut (.clk_sys(clk_sys),
      .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .srcPin(srcPin), .gatePin(gatePin),
      .hardwareArmInput(armPin), .ctrOut(ctrOut), .terminalCountPulse(tcPulse),
      .syncBusLine(syncBusLine));
   ext_terminal_model term (.clk_sys(clk_sys), .srcPin(srcPin), .gatePin(gatePin),
      .hardwareArmInput(armPin));
   always @(posedge clk_sys) begin
      tc0 += (tcPulse[0] === 1'b1);
      tc1 += (tcPulse[1] === 1'b1);
   end
   ////////////////////////////////////////////////////////////
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h000000, a};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : ahb
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   task automatic chkReg(input string nm, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      check(nm, e, q & m);
      check("hresp", 32'h0, {31'h0, hresp});
   endtask : chkReg
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   initial begin
      #1_000_000;
      fail_count++;
      test_done;
   end
   ////////////////////////////////////////////////////////////
   initial begin
      {hsel, hwrite, haddr, hwdata, htrans} = '0;
      hsize = 3'h2;
      resetn = 1'b0;
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chkReg("filt", `CT_FILT_OFS, 32'hffffffff, 32'h0);
      chkReg("gen0", `CT_GEN0_OFS, 32'hffffffff, 32'h00010001);
      chkReg("unmapped", 8'h3c, 32'hffffffff, 32'h0);
      // Finite, gate-started, retriggerable: two pulses a launch
      ahb(1'b1, `CT_GEN0_OFS, 32'h00020001);
      ahb(1'b1, `CT_CFG0_OFS, 32'h486);
      repeat (10) @(posedge clk_sys);
      check("out0 unarmed", 32'h0, {31'h0, ctrOut[0]});
      ahb(1'b1, `CT_CMD_OFS, 32'h1);
      chkReg("stat0 wait", `CT_STAT_OFS, 32'hf, 32'h2);
      term.pulse(2, 1, 4);
      repeat (20) @(posedge clk_sys);
      check("tc0 first", 32'd2, tc0);
      chkReg("stat0 done", `CT_STAT_OFS, 32'hf, 32'h8);
      term.pulse(2, 1, 4);
      repeat (20) @(posedge clk_sys);
      check("tc0 retrig", 32'd4, tc0);
      // Continuous on counter 1, runs only while its gate is high
      ahb(1'b1, `CT_CFG1_OFS, 32'h307);
      ahb(1'b1, `CT_CMD_OFS, 32'h4);
      repeat (20) @(posedge clk_sys);
      check("tc1 paused", 32'd0, tc1);
      term.setPin(3, 1'b1);
      repeat (20) @(posedge clk_sys);
      check("tc1 running", 32'd1, tc1 > 4);
      ahb(1'b1, `CT_CMD_OFS, 32'h8);
      chkReg("stat1 stop", `CT_STAT_OFS, 32'h2f0, 32'h10);
      // Edge count through the divide-by-8 prescaler
      ahb(1'b1, `CT_CMD_OFS, 32'h2);
      ahb(1'b1, `CT_CFG0_OFS, 32'h1000);
      ahb(1'b1, `CT_CMD_OFS, 32'h1);
      ahb(1'b0, `CT_CNT0_OFS, 32'h0);
      base = q;
      term.pulse(0, 16, 4);
      chkReg("cnt0 presc", `CT_CNT0_OFS, 32'hffffffff, base + 2);
      term.pulse(0, 7, 4);
      chkReg("cnt0 remainder", `CT_CNT0_OFS, 32'hffffffff, base + 2);
      // Filter N=5 on the count pin: short glitches never count
      ahb(1'b1, `CT_CMD_OFS, 32'h2);
      ahb(1'b1, `CT_CFG0_OFS, 32'h0);
      ahb(1'b1, `CT_FILT_OFS, 32'h1);
      ahb(1'b1, `CT_CMD_OFS, 32'h1);
      ahb(1'b0, `CT_CNT0_OFS, 32'h0);
      base = q;
      term.pulse(0, 4, 3);
      chkReg("cnt0 glitch", `CT_CNT0_OFS, 32'hffffffff, base);
      term.pulse(0, 3, 8);
      chkReg("cnt0 filtered", `CT_CNT0_OFS, 32'hffffffff, base + 3);
      // Bypass forwards the raw pin despite the filter
      ahb(1'b1, `CT_FILT_OFS, 32'h1001);
      term.setPin(0, 1'b1);
      repeat (6) @(posedge clk_sys);
      check("sync line", 32'h1, {26'h0, syncBusLine});
      term.setPin(0, 1'b0);
      // Edge count paused while its gate pin is low, run polarity high
      ahb(1'b1, `CT_CMD_OFS, 32'h2);
      ahb(1'b1, `CT_CFG0_OFS, 32'h300);
      ahb(1'b1, `CT_CMD_OFS, 32'h1);
      term.pulse(0, 2, 8);
      chkReg("cnt0 paused", `CT_CNT0_OFS, 32'hffffffff, 32'h0);
      term.setPin(2, 1'b1);
      term.pulse(0, 2, 8);
      chkReg("cnt0 resumed", `CT_CNT0_OFS, 32'hffffffff, 32'h2);
      // Hardware arm on counter 1
      ahb(1'b1, `CT_CFG1_OFS, 32'h46);
      repeat (10) @(posedge clk_sys);
      chkReg("stat1 unarmed", `CT_STAT_OFS, 32'hf0, 32'h10);
      term.pulse(5, 1, 4);
      chkReg("stat1 armed", `CT_STAT_OFS, 32'hf0, 32'h80);
      // Period capture: gate rises every 14 ticks of the medium timebase
      ahb(1'b1, `CT_CMD_OFS, 32'h8);
      ahb(1'b1, `CT_CFG1_OFS, 32'h5);
      ahb(1'b1, `CT_CMD_OFS, 32'h4);
      term.setPin(3, 1'b0);
      term.pulse(3, 2, 4);
      chkReg("cap1 period", `CT_CAP1_OFS, 32'hffffffff, 32'he);
      test_done;
   end
endmodule : counter_trigger_filter_prescale_tb_top

// [bench/ext_terminal_model.sv]
// Terminal-side model: count, gate and arm pins of both counters
// Assumes callers run in step with clk_sys; pins change after rising edges
`timescale 1ns/1ns
module ext_terminal_model (
   // Clock
   input  wire logic       clk_sys,
   // Terminals
   output logic      [1:0] srcPin,
   output logic      [1:0] gatePin,
   output logic      [1:0] hardwareArmInput
);
   logic [5:0] pinQ = 6'h00;
   // Same index order as the sync line bypass: src, gate, arm
   assign srcPin           = pinQ[1:0];
   assign gatePin          = pinQ[3:2];
   assign hardwareArmInput = pinQ[5:4];
   ////////////////////////////////////////////////////////////
   task automatic setPin(input int k, input logic v);
      @(posedge clk_sys);
      pinQ[k] <= v;
   endtask : setPin
   // Low gap of 9 cycles outlasts the shortest filter on falls too
   task automatic pulse(input int k, input int n, input int hi);
      for (int i = 0; i < n; i++) begin
         setPin(k, 1'b1);
         repeat (hi) @(posedge clk_sys);
         setPin(k, 1'b0);
         repeat (8) @(posedge clk_sys);
      end
   endtask : pulse
endmodule : ext_terminal_model

// [src/counter_trigger_filter_prescale.sv]
// Arm, start and pause triggering, filters and prescalers for two counters
// Assumes pins are asynchronous to clk_sys and a single AHB-Lite master
`timescale 1ns/1ns
`include "ctr_trig_map.svh"
////////////////////////////////////////////////////////////
module counter_trigger_filter_prescale #(
   parameter int unsigned LONG_FILT_N = `CT_FILT_N_LONG
) (
   // Clock and reset
   input  logic        clk_sys,
   input  logic        resetn,
   // AHB-Lite slave
   input  logic        hsel,
   input  logic [31:0] haddr,
   input  logic [1:0]  htrans,
   input  logic        hwrite,
   input  logic [2:0]  hsize,
   input  logic [31:0] hwdata,
   input  logic        hready,
   output logic        hreadyout,
   output logic        hresp,
   output logic [31:0] hrdata,
   // Terminals
   input  logic [1:0]  srcPin,
   input  logic [1:0]  gatePin,
   input  logic [1:0]  hardwareArmInput,
   // Counter outputs
   output logic [1:0]  ctrOut,
   output logic [1:0]  terminalCountPulse,
   output logic [5:0]  syncBusLine
);
   ////////////////////////////////////////////////////////////
   // Bus slave state
   logic        wrPend_q;
   logic [7:0]  wrAddr_q;
   logic [31:0] rdData_q;
   logic        ready_q;
   logic        resp_q;
   logic [17:0] filtCfg_q;
   logic [13:0] cfg_q [2];
   logic [31:0] gen_q [2];
   wire  [7:0]  hA       = haddr[7:0];
   wire         addrPh   = hsel && htrans[1] && hready;
   wire         cmdWr    = wrPend_q && wrAddr_q == `CT_CMD_OFS;
   wire         filtWr   = wrPend_q && wrAddr_q == `CT_FILT_OFS;
   wire  [31:0] rdK [2];
   wire  [31:0] rdCommon;
   wire  [31:0] rdData;

   // Pins and filters
   logic [5:0]  sync1_q;
   logic [5:0]  sync2_q;
   logic [5:0]  filtPrev_q;
   logic [5:0]  syncOut_q;
   wire  [5:0]  rawPins = {hardwareArmInput, gatePin, srcPin};
   wire  [5:0]  filt;

   // Timebase
   logic [7:0]  slowCnt_q;
   logic        slowTick_q;
   wire         slowWrap = slowCnt_q == 8'(`CT_SLOW_DIV - 1);

   // Counter state
   ctr_trig_pkg::ctrState_t st_q [2];
   logic [31:0] cnt_q     [2];
   logic [31:0] cap_q     [2];
   logic        capPend_q [2];
   logic [15:0] half_q    [2];
   logic [15:0] pls_q     [2];
   logic        out_q     [2];
   logic        tc_q      [2];
   logic [1:0]  gatePrev_q;
   wire  [1:0]  gateLvl;
   wire  [1:0]  srcTick;
   wire  [1:0]  armHit;
   wire  [1:0]  cmdStop;

   ////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait state, always OKAY
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= '0;
         rdData_q <= '0;
         ready_q  <= 1'b0;
         resp_q   <= 1'b0;
      end else begin
         ready_q  <= 1'b1;
         resp_q   <= 1'b0;
         wrPend_q <= addrPh && hwrite;
         if (addrPh) wrAddr_q <= hA;
         if (addrPh && !hwrite) rdData_q <= rdData;
      end
   end
   assign hreadyout = ready_q;
   assign hresp     = resp_q;
   assign hrdata    = rdData_q;

   // Filter settings are held per input and come up disabled
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) filtCfg_q <= `CT_FILT_RST;
      else if (filtWr) filtCfg_q <= hwdata[17:0];
   end

   assign rdCommon = (hA == `CT_FILT_OFS) ? {14'h0000, filtCfg_q} :
                     (hA == `CT_STAT_OFS) ?
                     {22'h000000, out_q[1], out_q[0], st_q[1], st_q[0]} : 32'h0000_0000;
   assign rdData   = rdK[0] | rdK[1] | rdCommon;

   ////////////////////////////////////////////////////////////
   // Synchronisers, filters and direct sync line forwarding
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sync1_q    <= '0;
         sync2_q    <= '0;
         filtPrev_q <= '0;
         syncOut_q  <= '0;
         gatePrev_q <= '0;
      end else begin
         sync1_q    <= rawPins;
         sync2_q    <= sync1_q;
         filtPrev_q <= filt;
         gatePrev_q <= gateLvl;
         syncOut_q  <= sync2_q & filtCfg_q[`CT_F_BYPASS +: 6];
      end
   end
   assign syncBusLine = syncOut_q;

   genvar i;
   generate
      for (i = 0; i < 6; i++) begin : g_in
         input_filter #(
            .LONG_N   (LONG_FILT_N)
         ) u_filt (
            .clk_sys  (clk_sys),
            .resetn   (resetn),
            .sampleIn (sync2_q[i]),
            .setting  (filtCfg_q[2*i +: 2]),
            .filtOut  (filt[i])
         );
      end
   endgenerate

   // Slow timebase enable; the medium timebase is clk_sys itself
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         slowCnt_q  <= '0;
         slowTick_q <= 1'b0;
      end else begin
         slowCnt_q  <= slowWrap ? 8'h00 : slowCnt_q + 8'h01;
         slowTick_q <= slowWrap;
      end
   end

   ////////////////////////////////////////////////////////////
   // Per counter triggering, counting and generation
   genvar k;
   generate
      for (k = 0; k < 2; k++) begin : g_ctr
         localparam logic [7:0] CFG_A = k ? `CT_CFG1_OFS : `CT_CFG0_OFS;
         localparam logic [7:0] GEN_A = k ? `CT_GEN1_OFS : `CT_GEN0_OFS;
         localparam logic [7:0] CNT_A = k ? `CT_CNT1_OFS : `CT_CNT0_OFS;
         localparam logic [7:0] CAP_A = k ? `CT_CAP1_OFS : `CT_CAP0_OFS;
         wire [1:0] mode    = cfg_q[k][`CT_F_MODE +: 2];
         wire [1:0] srcSel  = cfg_q[k][`CT_F_SRC +: 2];
         wire [1:0] gateSel = cfg_q[k][`CT_F_GATE +: 2];
         wire       hwArmEn = cfg_q[k][`CT_F_HWARM];
         wire       startEn = cfg_q[k][`CT_F_START];
         wire       pauseEn = cfg_q[k][`CT_F_PAUSE];
         wire       pausePol = cfg_q[k][`CT_F_PPOL];
         wire       retrig  = cfg_q[k][`CT_F_RETRIG];
         wire       dupPrev = cfg_q[k][`CT_F_DUP];
         wire       isGen   = mode[1];
         wire       internal = srcSel == 2'h1 || srcSel == 2'h2;
         wire [1:0] prescSel = internal ? ctr_trig_pkg::PRE_OFF : cfg_q[k][`CT_F_PRESC +: 2];
         wire       gateRise = gateLvl[k] && !gatePrev_q[k];
         wire       paused  = pauseEn && (gateLvl[k] != pausePol);
         wire       srcEdge;
         wire       halfEnd = {1'b0, half_q[k]} + 17'h00001 >= {1'b0, gen_q[k][15:0]};
         wire       plsEnd  = {1'b0, pls_q[k]} + 17'h00001 >= {1'b0, gen_q[k][31:16]};
         wire       cfgWr   = wrPend_q && wrAddr_q == CFG_A;
         wire       genWr   = wrPend_q && wrAddr_q == GEN_A;

         // Start and pause triggers share the gate; the other counter cascades in
         assign gateLvl[k] = (gateSel == 2'h1) ? out_q[1-k] :
                             (gateSel == 2'h2) ? tc_q[1-k] : filt[2+k];
         assign srcEdge = (srcSel == 2'h0) ? (filt[k] && !filtPrev_q[k]) :
                          (srcSel == 2'h1) ? 1'b1 :
                          (srcSel == 2'h2) ? slowTick_q : gateRise;
         assign armHit[k] = (cmdWr && hwdata[2*k + `CT_CMD_ARM]) ||
                            (hwArmEn && filt[4+k] && !filtPrev_q[4+k]);
         assign cmdStop[k] = cmdWr && hwdata[2*k + `CT_CMD_STOP];

         source_prescaler u_presc (
            .clk_sys (clk_sys),
            .resetn  (resetn),
            .tickIn  (srcEdge),
            .mode    (prescSel),
            .tickOut (srcTick[k])
         );

         assign rdK[k] = (hA == CFG_A) ? {18'h00000, cfg_q[k]} :
                         (hA == GEN_A) ? gen_q[k] :
                         (hA == CNT_A) ? cnt_q[k] :
                         (hA == CAP_A) ? cap_q[k] : 32'h0000_0000;

         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               cfg_q[k] <= `CT_CFG_RST;
               gen_q[k] <= `CT_GEN_RST;
            end else begin
               if (cfgWr) cfg_q[k] <= hwdata[13:0];
               if (genWr) gen_q[k] <= hwdata;
            end
         end

         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               st_q[k]      <= ctr_trig_pkg::ST_IDLE;
               cnt_q[k]     <= '0;
               cap_q[k]     <= '0;
               capPend_q[k] <= 1'b0;
               half_q[k]    <= '0;
               pls_q[k]     <= '0;
               out_q[k]     <= 1'b0;
               tc_q[k]      <= 1'b0;
            end else begin
               tc_q[k] <= 1'b0;
               if (cmdStop[k]) begin
                  st_q[k]  <= ctr_trig_pkg::ST_IDLE;
                  out_q[k] <= 1'b0;
               end else begin
                  case (st_q[k])
                     ctr_trig_pkg::ST_IDLE: begin
                        if (armHit[k]) begin
                           cnt_q[k]     <= '0;
                           half_q[k]    <= '0;
                           pls_q[k]     <= '0;
                           capPend_q[k] <= 1'b0;
                           out_q[k]     <= 1'b0;
                           st_q[k] <= (isGen && startEn) ? ctr_trig_pkg::ST_WAIT
                                                         : ctr_trig_pkg::ST_RUN;
                        end
                     end
                     ctr_trig_pkg::ST_WAIT: begin
                        if (gateRise) st_q[k] <= ctr_trig_pkg::ST_RUN;
                     end
                     ctr_trig_pkg::ST_RUN: begin
                        if (isGen) begin
                           if (srcTick[k] && !(paused && mode == ctr_trig_pkg::MODE_CONT)) begin
                              if (halfEnd) begin
                                 half_q[k] <= '0;
                                 out_q[k]  <= ~out_q[k];
                                 if (out_q[k]) begin
                                    tc_q[k]  <= 1'b1;
                                    pls_q[k] <= pls_q[k] + 16'h0001;
                                    if (mode == ctr_trig_pkg::MODE_FINITE && plsEnd)
                                       st_q[k] <= ctr_trig_pkg::ST_DONE;
                                 end
                              end else begin
                                 half_q[k] <= half_q[k] + 16'h0001;
                              end
                           end
                        end else if (mode == ctr_trig_pkg::MODE_MEAS) begin
                           // Without prevention the gate is seen only at a source edge
                           if (gateRise && dupPrev) begin
                              cap_q[k] <= cnt_q[k];
                              cnt_q[k] <= {31'h00000000, srcTick[k]};
                           end else if (srcTick[k] && (capPend_q[k] || gateRise)) begin
                              cap_q[k]     <= cnt_q[k];
                              cnt_q[k]     <= 32'h0000_0001;
                              capPend_q[k] <= 1'b0;
                           end else begin
                              if (gateRise) capPend_q[k] <= 1'b1;
                              if (srcTick[k]) cnt_q[k] <= cnt_q[k] + 32'h0000_0001;
                           end
                        end else if (srcTick[k] && !paused) begin
                           cnt_q[k] <= cnt_q[k] + 32'h0000_0001;
                           tc_q[k]  <= &cnt_q[k];
                        end
                     end
                     ctr_trig_pkg::ST_DONE: begin
                        if (retrig && gateRise) begin
                           st_q[k]   <= ctr_trig_pkg::ST_RUN;
                           half_q[k] <= '0;
                           pls_q[k]  <= '0;
                        end
                     end
                     default: st_q[k] <= ctr_trig_pkg::ST_IDLE;
                  endcase
               end
            end
         end
         assign ctrOut[k]             = out_q[k];
         assign terminalCountPulse[k] = tc_q[k];

         armFirst_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q[k] == ctr_trig_pkg::ST_IDLE && !armHit[k])
            |=> (st_q[k] == ctr_trig_pkg::ST_IDLE && !tc_q[k] && $stable(cnt_q[k])))
            else $error("Counter acted while disarmed");
         hwArm_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q[k] == ctr_trig_pkg::ST_IDLE && hwArmEn && $rose(filt[4+k]) && !cmdStop[k])
            |=> st_q[k] != ctr_trig_pkg::ST_IDLE)
            else $error("Hardware arm edge ignored");
         startTrig_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q[k] == ctr_trig_pkg::ST_WAIT && gateRise && !cmdStop[k])
            |=> st_q[k] == ctr_trig_pkg::ST_RUN ##1 st_q[k] != ctr_trig_pkg::ST_WAIT)
            else $error("Start trigger did not launch generation");
         contRun_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q[k] == ctr_trig_pkg::ST_RUN && mode == ctr_trig_pkg::MODE_CONT && !cmdStop[k])
            |=> st_q[k] == ctr_trig_pkg::ST_RUN)
            else $error("Continuous generation ended without stop");
         finDone_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q[k] == ctr_trig_pkg::ST_DONE && $past(st_q[k]) == ctr_trig_pkg::ST_RUN)
            |-> (tc_q[k] && {1'b0, pls_q[k]} >= {1'b0, gen_q[k][31:16]}))
            else $error("Finite generation halted at wrong pulse count");
         retrig_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q[k] == ctr_trig_pkg::ST_DONE && retrig && gateRise && !cmdStop[k])
            |=> (st_q[k] == ctr_trig_pkg::ST_RUN && pls_q[k] == 16'h0000))
            else $error("Retrigger did not restart generation");
         pauseHold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q[k] == ctr_trig_pkg::ST_RUN && mode == ctr_trig_pkg::MODE_EDGE
             && paused && !cmdStop[k]) |=> $stable(cnt_q[k]))
            else $error("Counted while paused");
         finCover_c: cover property (@(posedge clk_sys) disable iff (!resetn)
            st_q[k] == ctr_trig_pkg::ST_RUN ##1 st_q[k] == ctr_trig_pkg::ST_DONE);
         retrigCover_c: cover property (@(posedge clk_sys) disable iff (!resetn)
            st_q[k] == ctr_trig_pkg::ST_DONE ##1 st_q[k] == ctr_trig_pkg::ST_RUN);
         capCover_c: cover property (@(posedge clk_sys) disable iff (!resetn)
            mode == ctr_trig_pkg::MODE_MEAS && $changed(cap_q[k]));
      end
   endgenerate
endmodule : counter_trigger_filter_prescale

// [src/ctr_trig_map.svh]
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the counter front end files
`ifndef CTR_TRIG_MAP_SVH
`define CTR_TRIG_MAP_SVH
// Byte offsets
`define CT_CMD_OFS      8'h00
`define CT_CFG0_OFS     8'h04
`define CT_CFG1_OFS     8'h08
`define CT_GEN0_OFS     8'h0c
`define CT_GEN1_OFS     8'h10
`define CT_FILT_OFS     8'h14
`define CT_CNT0_OFS     8'h18
`define CT_CNT1_OFS     8'h1c
`define CT_CAP0_OFS     8'h20
`define CT_CAP1_OFS     8'h24
`define CT_STAT_OFS     8'h28
// Command bits, counter k at 2k and 2k+1
`define CT_CMD_ARM      0
`define CT_CMD_STOP     1
// Configuration fields; CT_F_BYPASS is a filter register field
`define CT_F_MODE       0
`define CT_F_SRC        2
`define CT_F_GATE       4
`define CT_F_HWARM      6
`define CT_F_START      7
`define CT_F_PAUSE      8
`define CT_F_PPOL       9
`define CT_F_RETRIG     10
`define CT_F_PRESC      11
`define CT_F_DUP        13
`define CT_F_BYPASS     12
// Reset values
`define CT_CFG_RST      14'h0000
`define CT_GEN_RST      32'h0001_0001
`define CT_FILT_RST     18'h00000
// Timing
`define CT_CLK_HZ       20000000
`define CT_SLOW_HZ      100000
`define CT_SLOW_DIV     (`CT_CLK_HZ / `CT_SLOW_HZ)
`define CT_FILT_N_SHORT 17'h00005
`define CT_FILT_N_MID   17'h00101
`define CT_FILT_N_LONG  101800
`endif

// [src/ctr_trig_pkg.sv]
// Types shared by the counter front end
// Assumes the map header carries all numbers
package ctr_trig_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_RUN  = 4'b0100,
      ST_DONE = 4'b1000
   } ctrState_t;
   typedef enum logic [1:0] {
      MODE_EDGE = 2'h0, MODE_MEAS = 2'h1, MODE_FINITE = 2'h2, MODE_CONT = 2'h3
   } mode_t;
   typedef enum logic [1:0] {
      PRE_OFF = 2'h0, PRE_2X = 2'h1, PRE_8X = 2'h2
   } presc_t;
   typedef enum logic [1:0] {
      FILT_OFF = 2'h0, FILT_SHORT = 2'h1, FILT_MID = 2'h2, FILT_LONG = 2'h3
   } filt_t;
endpackage : ctr_trig_pkg

// [src/input_filter.sv]
// Debounce filter for one synchronised input
// Assumes sampleIn is already in the clk_sys domain
`timescale 1ns/1ns
`include "ctr_trig_map.svh"
module input_filter #(
   parameter int unsigned LONG_N = `CT_FILT_N_LONG
) (
   // Clock and reset
   input  logic       clk_sys,
   input  logic       resetn,
   // Data
   input  logic       sampleIn,
   input  logic [1:0] setting,
   output logic       filtOut
);
   logic [16:0] run_q;
   logic        out_q;
   wire         bypass = setting == ctr_trig_pkg::FILT_OFF;
   wire         differ = sampleIn != out_q;
   wire  [16:0] limit  = (setting == ctr_trig_pkg::FILT_SHORT) ? `CT_FILT_N_SHORT :
                         (setting == ctr_trig_pkg::FILT_MID)   ? `CT_FILT_N_MID :
                         17'(LONG_N);
   // Greater-or-equal so a shorter setting written mid-run cannot strand the count
   wire         lastOne = run_q >= limit - 17'h00001;

   // One sample per clk_sys edge; a slower sample rate stretches every setting
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         run_q <= '0;
         out_q <= 1'b0;
      end else if (bypass || !differ) begin
         run_q <= '0;
         if (bypass) out_q <= sampleIn;
      end else if (lastOne) begin
         run_q <= '0;
         out_q <= sampleIn;
      end else begin
         run_q <= run_q + 17'h00001;
      end
   end
   // Sampling granularity bounds the added jitter to one sample period
   assign filtOut = out_q;

   filtPass_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      ($changed(out_q) && $past(setting) == ctr_trig_pkg::FILT_SHORT
       && $past(setting, 5) == ctr_trig_pkg::FILT_SHORT)
      |-> ($past(sampleIn) == out_q && $past(sampleIn, 5) == out_q))
      else $error("Short filter passed fewer than five samples");
   filtHold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (!bypass && !differ && $stable(setting)) |=> $stable(out_q))
      else $error("Filter output moved after a matching sample");
endmodule : input_filter

// [src/source_prescaler.sv]
// Source prescaler: wrapping divide by 8, by 2, or pass through
// Assumes tickIn is a one-cycle pulse per source edge
`timescale 1ns/1ns
module source_prescaler (
   // Clock and reset
   input  logic       clk_sys,
   input  logic       resetn,
   // Ticks
   input  logic       tickIn,
   input  logic [1:0] mode,
   output logic       tickOut
);
   logic [2:0] cnt_q;
   logic       out_q;
   wire  [2:0] top  = (mode == ctr_trig_pkg::PRE_8X) ? 3'h7 : 3'h1;
   wire        off  = mode == ctr_trig_pkg::PRE_OFF;
   wire        wrap = cnt_q == top;

   // The wrap count has no read path, so a partial group is lost to software
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= '0;
         out_q <= 1'b0;
      end else begin
         out_q <= tickIn && (off || wrap);
         if (tickIn && !off) cnt_q <= wrap ? 3'h0 : cnt_q + 3'h1;
      end
   end
   assign tickOut = out_q;

   prescWrap_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (tickIn && mode == ctr_trig_pkg::PRE_8X && cnt_q == 3'h7) |=> (tickOut && cnt_q == 3'h0))
      else $error("Divide by eight missed its rollover");
   prescMid_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (tickIn && !off && !wrap) |=> !tickOut)
      else $error("Prescaler ticked before rollover");
endmodule : source_prescaler
